// ### design/selfprog_pkg.sv
// Constants, types and helpers for the self-programming access block
package selfprog_pkg;

  localparam int PC_W   = 12;
  localparam int PAGE_W = 7;
  localparam int WORD_W = 5;
  localparam int Z_W    = 16;
  localparam int WIN_W  = 3;

  // Z pointer field positions
  localparam int Z_PAGE_LSB = 6;
  localparam int Z_PAGE_MSB = 12;
  localparam int Z_WORD_LSB = 1;
  localparam int Z_WORD_MSB = 5;

  // Section map, word addresses
  localparam logic [PC_W-1:0] RW_SECTION_LIMIT = 12'hC00;
  localparam logic [PC_W-1:0] BOOT_START_128   = 12'hF80;
  localparam logic [PC_W-1:0] BOOT_START_256   = 12'hF00;
  localparam logic [PC_W-1:0] BOOT_START_512   = 12'hE00;
  localparam logic [PC_W-1:0] BOOT_START_1024  = 12'hC00;
  localparam logic [1:0]      BOOT_SEL_128     = 2'h3;
  localparam logic [1:0]      BOOT_SEL_256     = 2'h2;
  localparam logic [1:0]      BOOT_SEL_512     = 2'h1;
  localparam int              BOOT_SEL_LSB     = 1;

  // Timed windows, in CPU cycles
  localparam logic [WIN_W-1:0] LPM_WINDOW = 3'h3;
  localparam logic [WIN_W-1:0] SPM_WINDOW = 3'h4;

  // Programming time
  localparam int CLK_MHZ         = 50;
  localparam int PROG_MIN_NS     = 3_700_000;
  localparam int PROG_MAX_NS     = 4_500_000;
  localparam int PROG_MIN_CYCLES = (PROG_MIN_NS * CLK_MHZ + 999) / 1000;
  localparam int PROG_MAX_CYCLES = (PROG_MAX_NS * CLK_MHZ) / 1000;

  // APB register byte offsets
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_FUSE   = 8'h04;
  localparam logic [7:0] ADDR_LOCK   = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0C;

  // Control and status register fields
  localparam int CTRL_STORE_EN   = 0;
  localparam int CTRL_PAGE_ERASE = 1;
  localparam int CTRL_PAGE_WRITE = 2;
  localparam int CTRL_LOCK_SEL   = 3;
  localparam int CTRL_RWW_REEN   = 4;
  localparam int CTRL_RWW_BUSY   = 6;
  localparam int STATUS_OP_BUSY  = 12;

  localparam logic [4:0] CODE_LOAD  = 5'h01;
  localparam logic [4:0] CODE_ERASE = 5'h03;
  localparam logic [4:0] CODE_WRITE = 5'h05;
  localparam logic [4:0] CODE_LOCK  = 5'h09;
  localparam logic [4:0] CODE_RWWRE = 5'h11;

  localparam logic [7:0] FUSE_LOW_RST   = 8'hFF;
  localparam logic [7:0] FUSE_HIGH_RST  = 8'hFF;
  localparam logic [7:0] LOCK_RST       = 8'hFF;
  localparam logic [7:0] LOCK_KEEP_MASK = 8'hC3;

  localparam logic [1:0] ZSEL_FUSE_LOW  = 2'h0;
  localparam logic [1:0] ZSEL_LOCK      = 2'h1;
  localparam logic [1:0] ZSEL_FUSE_HIGH = 2'h3;

  typedef enum logic [2:0] {OP_LOAD, OP_ERASE, OP_WRITE, OP_LOCK, OP_RWWRE} op_t;

  typedef struct packed {
    logic            lpm;
    logic            spm;
    logic [Z_W-1:0]  z;
    logic [15:0]     data;
  } cpu_req_t;

  typedef struct packed {
    logic              wr;
    logic              clear;
    logic [WORD_W-1:0] index;
    logic [15:0]       data;
  } page_buf_t;

  typedef struct packed {
    logic              erase;
    logic              write;
    logic [PAGE_W-1:0] page;
  } flash_op_t;

  function automatic logic [PC_W-1:0] boot_start(input logic [1:0] sel);
    unique case (sel)
      BOOT_SEL_128: boot_start = BOOT_START_128;
      BOOT_SEL_256: boot_start = BOOT_START_256;
      BOOT_SEL_512: boot_start = BOOT_START_512;
      default:      boot_start = BOOT_START_1024;
    endcase
  endfunction : boot_start

  function automatic logic in_rw_section(input logic [PC_W-1:0] addr);
    in_rw_section = (addr < RW_SECTION_LIMIT);
  endfunction : in_rw_section

endpackage : selfprog_pkg

// ### design/flash_op_timer.sv
// Programming-time counter for erase, write and lock operations
`timescale 1ns/10ps
`default_nettype none
module flash_op_timer
  import selfprog_pkg::*;
#(
  parameter int unsigned CYCLES = PROG_MIN_CYCLES
) (
  input  wire logic core_clk,
  input  wire logic por_n,
  input  wire logic start,
  output logic      busy,
  output logic      done
);
  localparam int CNT_W = $clog2(CYCLES + 1);
  // One short, since done is registered and busy plus done must span CYCLES
  localparam logic [CNT_W-1:0] LOAD = CNT_W'(CYCLES - 1);
  localparam logic [CNT_W-1:0] ONE  = CNT_W'(1);

  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] next_cnt;
  logic             next_done;

  always_comb begin
    next_cnt  = cnt;
    next_done = 1'b0;
    if (start && cnt == '0) begin
      next_cnt = LOAD;
    end else if (cnt != '0) begin
      next_cnt  = cnt - ONE;
      next_done = (cnt == ONE);
    end
  end

  // Only power-on clears it, so a system reset lets a write finish
  always_ff @(posedge core_clk) begin
    if (!por_n) begin
      cnt  <= '0;
      done <= 1'b0;
    end else begin
      cnt  <= next_cnt;
      done <= next_done;
    end
  end

  assign busy = (cnt != '0);
endmodule : flash_op_timer
`default_nettype wire

// ### design/selfprog_fuse_readout_boot_map.sv
// Self-programming control, fuse and lock readout, and flash section map
`timescale 1ns/10ps
`default_nettype none
// Behaviour
// - Armed lock select with Z=0x0001, a load within three cycles returns the lock byte.
// - Select and enable clear after readout, or when the timed windows lapse.
// - With select and enable clear, a load returns ordinary program memory.
// - Armed with Z=0x0000, a load within three cycles returns the fuse low byte.
// - Armed with Z=0x0003, a load within three cycles returns the fuse high byte.
// - Programmed bits read as 0, unprogrammed bits read as 1.
// - A reset during a flash write lets the write finish.
// - Erase, write and lock write each last PROG_CYCLES cycles: 3.7 ms by default, at most 4.5 ms.
// - Two-bit boot size field picks 128..1024 words and the boot reset address.
// - Words 0x000-0xBFF are read-while-write, 0xC00-0xFFF are not.
// - Page index comes from Z12:Z6.
// - Buffer word comes from Z5:Z1; software keeps it zero for page write.
// - Z15:Z13 ignored; Z0 picks the byte on a load, zero for stores.
// - Program counter is 12 bits; a page holds 32 words.
// - Store enable opens a four-cycle window, stays set during erase or write.
// - Busy flag sets on read-while-write section erase or write, clears on re-enable or a page buffer store.
module selfprog_fuse_readout_boot_map
  import selfprog_pkg::*;
#(
  parameter int unsigned PROG_CYCLES = PROG_MIN_CYCLES
) (
  input  wire logic          core_clk,
  input  wire logic          rst_n,
  input  wire logic          por_n,
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [7:0]    paddr,
  input  wire logic [31:0]   pwdata,
  output logic      [31:0]   prdata,
  output logic               pready,
  output logic               pslverr,
  input  wire cpu_req_t      cpu,
  input  wire logic [15:0]   flash_word,
  input  wire logic          eeprom_write_busy,
  output logic      [7:0]    lpm_data,
  output logic               lpm_valid,
  output page_buf_t          page_buf,
  output flash_op_t          flash_op,
  output logic               cpu_halt,
  output logic               rww_busy,
  output logic [PC_W-1:0]    boot_reset_addr
);
  if (PROG_CYCLES < 2 || PROG_CYCLES > PROG_MAX_CYCLES) begin : g_chk
    $error("PROG_CYCLES out of range");
  end

  typedef enum logic [1:0] {ST_IDLE, ST_ARMED, ST_BUSY} st_t;

  st_t              st, next_st;
  op_t              op, next_op;
  logic [WIN_W-1:0] win_cnt, next_win_cnt;
  logic [7:0]       fuse_low, next_fuse_low;
  logic [7:0]       fuse_high, next_fuse_high;
  logic [7:0]       lock_byte, next_lock_byte;
  logic [7:0]       lock_data, next_lock_data;
  logic             next_rww_busy, next_cpu_halt, next_lpm_valid, next_pready, next_pslverr;
  logic [7:0]       next_lpm_data;
  logic [31:0]      next_prdata;
  page_buf_t        next_page_buf;
  flash_op_t        next_flash_op;
  logic [PC_W-1:0]  next_boot_reset_addr;
  logic             tmr_start, tmr_busy, tmr_done;
  logic             apb_wr, apb_rd_setup;
  logic [PC_W-1:0]  z_addr;
  logic [4:0]       code;
  logic             readout_ok;
  logic [31:0]      ctrl_val;

  flash_op_timer #(.CYCLES(PROG_CYCLES)) u_timer (
    .core_clk (core_clk),
    .por_n    (por_n),
    .start    (tmr_start),
    .busy     (tmr_busy),
    .done     (tmr_done)
  );

  assign z_addr       = cpu.z[Z_PAGE_MSB:Z_WORD_LSB];
  assign apb_wr       = psel && penable && pready && pwrite;
  assign apb_rd_setup = psel && penable && !pready;
  assign code         = pwdata[4:0];
  assign readout_ok   = (st == ST_ARMED) && (op == OP_LOCK) && (win_cnt < LPM_WINDOW);

  always_comb begin
    ctrl_val = '0;
    ctrl_val[CTRL_STORE_EN]   = (st != ST_IDLE);
    ctrl_val[CTRL_PAGE_ERASE] = (st != ST_IDLE) && (op == OP_ERASE);
    ctrl_val[CTRL_PAGE_WRITE] = (st != ST_IDLE) && (op == OP_WRITE);
    ctrl_val[CTRL_LOCK_SEL]   = (st != ST_IDLE) && (op == OP_LOCK);
    ctrl_val[CTRL_RWW_REEN]   = (st != ST_IDLE) && (op == OP_RWWRE);
    ctrl_val[CTRL_RWW_BUSY]   = rww_busy;
  end

  always_comb begin
    next_st        = st;
    next_op        = op;
    next_win_cnt   = win_cnt;
    next_fuse_low  = fuse_low;
    next_fuse_high = fuse_high;
    next_lock_byte = lock_byte;
    next_lock_data = lock_data;
    next_rww_busy  = rww_busy;
    next_cpu_halt  = cpu_halt;
    next_flash_op  = flash_op;
    next_lpm_valid = 1'b0;
    next_lpm_data  = lpm_data;
    next_page_buf  = '{wr: 1'b0, clear: 1'b0, index: page_buf.index, data: page_buf.data};
    tmr_start      = 1'b0;
    next_boot_reset_addr = boot_start(fuse_high[BOOT_SEL_LSB +: 2]);

    // Register bus: one wait state, then the access completes
    next_pready  = apb_rd_setup;
    next_pslverr = 1'b0;
    next_prdata  = '0;
    if (apb_rd_setup) begin
      unique case (paddr)
        ADDR_CTRL:   next_prdata = ctrl_val;
        ADDR_FUSE:   next_prdata = {16'h0000, fuse_high, fuse_low};
        ADDR_LOCK:   next_prdata = {24'h000000, lock_byte};
        ADDR_STATUS: next_prdata = {19'h00000, (st == ST_BUSY), boot_reset_addr};
        default:     next_pslverr = 1'b1;
      endcase
    end
    if (apb_wr && paddr == ADDR_FUSE) begin
      next_fuse_low  = pwdata[7:0];
      next_fuse_high = pwdata[15:8];
    end

    // Loads: ordinary byte unless the readout window is open
    if (cpu.lpm) begin
      next_lpm_valid = 1'b1;
      if (readout_ok) begin
        unique case (cpu.z[1:0])
          ZSEL_FUSE_LOW:  next_lpm_data = fuse_low;
          ZSEL_LOCK:      next_lpm_data = lock_byte;
          ZSEL_FUSE_HIGH: next_lpm_data = fuse_high;
          default:        next_lpm_data = 8'hFF;
        endcase
      end else begin
        next_lpm_data = cpu.z[0] ? flash_word[15:8] : flash_word[7:0];
      end
    end

    unique case (st)
      ST_IDLE: begin
        // Arming is refused while an EEPROM write runs
        if (apb_wr && paddr == ADDR_CTRL && !eeprom_write_busy) begin
          next_win_cnt = '0;
          next_st      = ST_ARMED;
          unique case (code)
            CODE_LOAD:  next_op = OP_LOAD;
            CODE_ERASE: next_op = OP_ERASE;
            CODE_WRITE: next_op = OP_WRITE;
            CODE_LOCK:  next_op = OP_LOCK;
            CODE_RWWRE: next_op = OP_RWWRE;
            default:    next_st = ST_IDLE;
          endcase
        end
      end
      ST_ARMED: begin
        next_win_cnt = win_cnt + 3'h1;
        if (cpu.lpm && readout_ok) begin
          next_st = ST_IDLE;
        end else if (cpu.spm) begin
          next_st = ST_IDLE;
          unique case (op)
            OP_LOAD: begin
              next_page_buf.wr    = 1'b1;
              next_page_buf.index = cpu.z[Z_WORD_MSB:Z_WORD_LSB];
              next_page_buf.data  = cpu.data;
              next_rww_busy       = 1'b0;
            end
            OP_ERASE, OP_WRITE: begin
              next_st             = ST_BUSY;
              tmr_start           = 1'b1;
              next_flash_op.erase = (op == OP_ERASE);
              next_flash_op.write = (op == OP_WRITE);
              next_flash_op.page  = cpu.z[Z_PAGE_MSB:Z_PAGE_LSB];
              // CPU stalls only when its own fetch section is the target
              if (in_rw_section(z_addr)) begin
                next_rww_busy = 1'b1;
              end else begin
                next_cpu_halt = 1'b1;
              end
            end
            OP_LOCK: begin
              next_st        = ST_BUSY;
              tmr_start      = 1'b1;
              next_lock_data = cpu.data[7:0];
            end
            OP_RWWRE: begin
              next_rww_busy       = 1'b0;
              next_page_buf.clear = 1'b1;
            end
          endcase
        end else if (win_cnt == SPM_WINDOW - 3'h1) begin
          next_st = ST_IDLE;
        end
      end
      ST_BUSY: begin
        if (tmr_done) begin
          next_st             = ST_IDLE;
          next_cpu_halt       = 1'b0;
          next_flash_op.erase = 1'b0;
          next_flash_op.write = 1'b0;
          next_page_buf.clear = (op == OP_WRITE);
          if (op == OP_LOCK) begin
            next_lock_byte = lock_byte & (lock_data | LOCK_KEEP_MASK);
          end
        end
      end
    endcase

    // System reset drops windows and bus answers but never a running write
    if (!rst_n) begin
      next_pready    = 1'b0;
      next_pslverr   = 1'b0;
      next_prdata    = '0;
      next_lpm_valid = 1'b0;
      next_page_buf.wr = 1'b0;
      if (st != ST_BUSY) begin
        next_st             = ST_IDLE;
        next_win_cnt        = '0;
        next_page_buf.clear = 1'b1;
        tmr_start           = 1'b0;
        next_cpu_halt       = 1'b0;
        next_flash_op.erase = 1'b0;
        next_flash_op.write = 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!por_n) begin
      st              <= ST_IDLE;
      op              <= OP_LOAD;
      win_cnt         <= '0;
      fuse_low        <= FUSE_LOW_RST;
      fuse_high       <= FUSE_HIGH_RST;
      lock_byte       <= LOCK_RST;
      lock_data       <= LOCK_RST;
      rww_busy        <= 1'b0;
      cpu_halt        <= 1'b0;
      flash_op        <= '0;
      lpm_valid       <= 1'b0;
      lpm_data        <= '0;
      page_buf        <= '0;
      prdata          <= '0;
      pready          <= 1'b0;
      pslverr         <= 1'b0;
      boot_reset_addr <= BOOT_START_128;
    end else begin
      st              <= next_st;
      op              <= next_op;
      win_cnt         <= next_win_cnt;
      fuse_low        <= next_fuse_low;
      fuse_high       <= next_fuse_high;
      lock_byte       <= next_lock_byte;
      lock_data       <= next_lock_data;
      rww_busy        <= next_rww_busy;
      cpu_halt        <= next_cpu_halt;
      flash_op        <= next_flash_op;
      lpm_valid       <= next_lpm_valid;
      lpm_data        <= next_lpm_data;
      page_buf        <= next_page_buf;
      prdata          <= next_prdata;
      pready          <= next_pready;
      pslverr         <= next_pslverr;
      boot_reset_addr <= next_boot_reset_addr;
    end
  end

  // Checks
  logic [31:0] busy_len;
  always_ff @(posedge core_clk) begin
    if (!por_n) begin
      busy_len <= '0;
    end else if (st == ST_BUSY) begin
      busy_len <= busy_len + 32'h1;
    end else begin
      busy_len <= '0;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!por_n);

  a_lock_readout: assert property (readout_ok && cpu.lpm && cpu.z[1:0] == ZSEL_LOCK && rst_n
    |=> lpm_valid && lpm_data == $past(lock_byte) && st == ST_IDLE) else $error("lock readout wrong");
  a_window_lapse: assert property ($rose(st == ST_ARMED) ##0 (!cpu.spm && !cpu.lpm)[*4]
    |=> st == ST_IDLE) else $error("window did not close");
  a_plain_load: assert property (cpu.lpm && !readout_ok && rst_n
    |=> lpm_data == ($past(cpu.z[0]) ? $past(flash_word[15:8]) : $past(flash_word[7:0])))
    else $error("plain load wrong");
  a_fuse_low_read: assert property (readout_ok && cpu.lpm && cpu.z[1:0] == ZSEL_FUSE_LOW && rst_n
    |=> lpm_data == $past(fuse_low)) else $error("fuse low readout wrong");
  a_fuse_high_read: assert property (readout_ok && cpu.lpm && cpu.z[1:0] == ZSEL_FUSE_HIGH && rst_n
    |=> lpm_data == $past(fuse_high)) else $error("fuse high readout wrong");
  a_reset_keeps_op: assert property (st == ST_BUSY && !rst_n && !tmr_done
    |=> st == ST_BUSY) else $error("reset aborted a write");
  a_op_length: assert property ($fell(st == ST_BUSY) |-> busy_len == PROG_CYCLES)
    else $error("programming time wrong");
  a_boot_addr_map: assert property (##1 boot_reset_addr == boot_start($past(fuse_high[BOOT_SEL_LSB +: 2])))
    else $error("boot start wrong");
  a_rww_busy_set: assert property (st == ST_ARMED && cpu.spm && rst_n && (op == OP_ERASE || op == OP_WRITE)
    |=> rww_busy == in_rw_section($past(z_addr)) || $past(rww_busy)) else $error("busy flag wrong");
  a_page_map: assert property (st == ST_ARMED && cpu.spm && rst_n && op == OP_ERASE
    |=> flash_op.erase && flash_op.page == $past(cpu.z[Z_PAGE_MSB:Z_PAGE_LSB])) else $error("page wrong");
  a_word_map: assert property (page_buf.wr |-> page_buf.index == $past(cpu.z[Z_WORD_MSB:Z_WORD_LSB]) && !rww_busy)
    else $error("word index wrong");
  a_timer_running: assert property (st == ST_BUSY && !tmr_done |-> tmr_busy)
    else $error("timer idle during operation");

  c_lock_read:  cover property (readout_ok && cpu.lpm && cpu.z[1:0] == ZSEL_LOCK);
  c_erase_done: cover property ($fell(st == ST_BUSY) && op == OP_ERASE);
  c_page_load:  cover property (page_buf.wr);
  c_reenable:   cover property ($fell(rww_busy));
endmodule : selfprog_fuse_readout_boot_map
`default_nettype wire

// ### dv/cpu_model.sv
// Behavioural CPU core issuing load and store instructions
`timescale 1ns/10ps
`default_nettype none
module cpu_model
  import selfprog_pkg::*;
(
  input  wire logic   core_clk,
  output var cpu_req_t cpu,
  output logic [15:0] flash_word
);
  logic [15:0] pat;

  assign pat = {cpu.z[8:1], ~cpu.z[8:1]};
  // Inverted outside a load so stale data never passes for a match
  assign flash_word = cpu.lpm ? pat : ~pat;

  initial begin
    cpu = '0;
  end

  task automatic lpm(input logic [15:0] z);
    cpu.lpm <= 1'b1;
    cpu.z   <= z;
    @(posedge core_clk);
    cpu.lpm <= 1'b0;
    @(posedge core_clk);
  endtask : lpm

  task automatic spm(input logic [15:0] z, input logic [15:0] d);
    cpu.spm  <= 1'b1;
    cpu.z    <= z & 16'hFFFE;
    cpu.data <= d;
    @(posedge core_clk);
    cpu.spm <= 1'b0;
  endtask : spm
endmodule : cpu_model
`default_nettype wire

// ### dv/tb_top.sv
// Self-checking bench for the self-programming access block
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import selfprog_pkg::*;
  localparam int PC = 20;
  typedef struct packed {
    logic [15:0] fuse;
    logic [15:0] z;
    logic [7:0]  exp;
    logic [11:0] boot;
  } row_t;
  logic        core_clk, rst_n, por_n, psel, penable, pwrite, pready, pslverr, perr;
  logic        eeprom_write_busy, lpm_valid, cpu_halt, rww_busy;
  logic [7:0]  paddr, lpm_data;
  logic [31:0] pwdata, prdata, r;
  logic [15:0] flash_word;
  logic [11:0] boot_reset_addr;
  cpu_req_t    cpu;
  page_buf_t   pbuf;
  flash_op_t   fop;
  int          num_errors, n_checks, cyc;
  row_t        rows [4];

  selfprog_fuse_readout_boot_map #(.PROG_CYCLES(PC)) u_dut (
    .core_clk(core_clk), .rst_n(rst_n), .por_n(por_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cpu(cpu), .flash_word(flash_word), .eeprom_write_busy(eeprom_write_busy),
    .lpm_data(lpm_data), .lpm_valid(lpm_valid), .page_buf(pbuf), .flash_op(fop),
    .cpu_halt(cpu_halt), .rww_busy(rww_busy), .boot_reset_addr(boot_reset_addr));
  cpu_model u_cpu (.core_clk(core_clk), .cpu(cpu), .flash_word(flash_word));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic summarize();
    $display("checks=%0d errors=%0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : summarize

  // Called at a rising edge; waits on pready, no assumed latency
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    r       = prdata;
    perr    = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic arm(input logic [4:0] code);
    do begin
      apb(1'b0, ADDR_CTRL, '0);
      @(posedge core_clk);
    end while (r[CTRL_STORE_EN] !== 1'b0 || eeprom_write_busy);
    apb(1'b1, ADDR_CTRL, {27'h0, code});
  endtask : arm

  task automatic prog(input logic [4:0] c, input logic [15:0] z, input logic [6:0] pg,
                      input logic halt, input logic rb, input logic rs);
    int n;
    arm(c);
    u_cpu.spm(z, 16'h0);
    @(posedge core_clk);
    chk({23'h0, cpu_halt, rww_busy, fop.page}, {23'h0, halt, rb, pg});
    n = 0;
    while ((fop.erase | fop.write) === 1'b1 && n < 1000) begin
      if (n == 2 && rs) rst_n <= 1'b0;
      if (n == 4) rst_n <= 1'b1;
      n++;
      @(posedge core_clk);
    end
    chk(n, PC);
  endtask : prog

  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  // Hang guard; run needs well under a thousand cycles
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 5000) begin
      num_errors++;
      summarize();
    end
  end

  initial begin
    {rst_n, por_n, psel, penable, pwrite, eeprom_write_busy} = '0;
    paddr  = '0;
    pwdata = '0;
    rows   = '{'{16'hC63C, 16'h0000, 8'h3C, 12'hF80}, '{16'h34A1, 16'h0003, 8'h34, 12'hF00},
               '{16'h5A0F, 16'hE003, 8'h5A, 12'hE00}, '{16'h9977, 16'h0001, 8'hFF, 12'hC00}};
    repeat (10) @(posedge core_clk);
    rst_n <= 1'b1;
    por_n <= 1'b1;
    @(posedge core_clk);
    apb(1'b0, ADDR_FUSE, '0);
    chk(r, 32'h0000FFFF);
    @(posedge core_clk);
    apb(1'b0, ADDR_STATUS, '0);
    chk(r, 32'h00000F80);
    foreach (rows[i]) begin
      @(posedge core_clk);
      apb(1'b1, ADDR_FUSE, {16'h0, rows[i].fuse});
      @(posedge core_clk);
      arm(CODE_LOCK);
      u_cpu.lpm(rows[i].z);
      chk({23'h0, lpm_valid, lpm_data}, {23'h0, 1'b1, rows[i].exp});
      chk({20'h0, boot_reset_addr}, {20'h0, rows[i].boot});
      apb(1'b0, ADDR_CTRL, '0);
      chk(r, 32'h0);
    end
    // Plain load, high byte
    u_cpu.lpm(16'h0101);
    chk({24'h0, lpm_data}, 32'h80);
    arm(CODE_LOCK);
    repeat (3) @(posedge core_clk);
    u_cpu.lpm(16'h0001);
    chk({24'h0, lpm_data}, 32'h00);
    arm(CODE_LOAD);
    repeat (5) @(posedge core_clk);
    u_cpu.spm(16'h0002, 16'hBEEF);
    @(posedge core_clk);
    chk({31'h0, pbuf.wr}, 32'h0);
    prog(CODE_ERASE, 16'hE140, 7'h05, 1'b0, 1'b1, 1'b0);
    arm(CODE_LOAD);
    u_cpu.spm(16'h003E, 16'h1234);
    @(posedge core_clk);
    chk({10'h0, pbuf.wr, pbuf.index, pbuf.data}, {10'h0, 1'b1, 5'h1F, 16'h1234});
    @(posedge core_clk);
    chk({31'h0, rww_busy}, 32'h0);
    // Reset mid write must not cut it short
    prog(CODE_WRITE, 16'h0080, 7'h02, 1'b0, 1'b1, 1'b1);
    arm(CODE_RWWRE);
    u_cpu.spm(16'h0000, 16'h0);
    @(posedge core_clk);
    chk({31'h0, pbuf.clear}, 32'h1);
    @(posedge core_clk);
    chk({31'h0, rww_busy}, 32'h0);
    prog(CODE_ERASE, 16'h1800, 7'h60, 1'b1, 1'b0, 1'b0);
    arm(CODE_LOCK);
    u_cpu.spm(16'h0001, 16'h0000);
    arm(CODE_LOCK);
    u_cpu.lpm(16'h0001);
    chk({24'h0, lpm_data}, 32'hC3);
    apb(1'b1, ADDR_LOCK, '0);
    @(posedge core_clk);
    apb(1'b0, ADDR_LOCK, '0);
    chk(r, 32'hC3);
    eeprom_write_busy <= 1'b1;
    @(posedge core_clk);
    apb(1'b1, ADDR_CTRL, 32'h9);
    @(posedge core_clk);
    apb(1'b0, ADDR_CTRL, '0);
    chk(r, 32'h0);
    eeprom_write_busy <= 1'b0;
    @(posedge core_clk);
    apb(1'b0, 8'h10, '0);
    chk({r[30:0], perr}, 32'h1);
    summarize();
  end
endmodule : tb_top
`default_nettype wire
